// >>> logic/epvu_unit.sv
// Exception arbitration, preemption and vector address unit
// Operation
// R1 - Vectors 0-15 are core exceptions; interrupt n uses vector n+16, entry 4*vector.
// R2 - Table holds initial stack pointer first, then handler addresses by vector number.
// R3 - Software sets bit 0 of every handler address to one.
// R4 - After reset the table base is address zero.
// R5 - Only privileged writes move the base, within the lower and upper limits.
// R6 - Software aligns a relocated base to 256 bytes.
// R7 - Smaller priority value means more urgent, for selection and preemption.
// R8 - Reset, NMI and hard fault are fixed; all others configurable.
// R9 - Configurable priorities reset to zero.
// R10 - Configurable priorities hold values zero to seven only.
// R11 - Fixed negative priorities always outrank configurable exceptions.
// R12 - Equal priorities resolve to the lowest exception number.
// R13 - Running handler is preempted only by strictly more urgent pending exception.
// R14 - Equal priority never preempts, even with lower exception number.
// R15 - An exception that cannot preempt stays recorded as pending.
// R16 - NMI always enabled, fixed at minus two, outranked only by reset.
// R17 - Hard fault fixed at minus one, below NMI and reset.
// R18 - Pending stays set until the core accepts; clears when exception becomes active.
`timescale 1ns/100ps
module epvu_unit (
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  input  wire epvu_pkg::epvu_req_type    req,
  input  wire epvu_pkg::epvu_prio_wr_type prio_wr,
  input  wire epvu_pkg::epvu_base_wr_type base_wr,
  input  wire epvu_pkg::epvu_core_type   core,
  output logic                           take_valid,
  output logic [5:0]                     take_number,
  output logic [31:0]                    take_addr,
  output logic [3:0]                     take_prio,
  output logic [3:0]                     run_prio,
  output logic [59:0]                    pending,
  output logic [59:0]                    active,
  output logic [31:0]                    table_base
);
  import epvu_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [3:0] eff_level(input logic [5:0] num, input logic [2:0] lvl);
    logic [3:0] res;
    // R8 R16 R17 fixed levels
    case (num)
      EXC_RESET: res = PRIO_RESET;
      EXC_NMI:   res = PRIO_NMI;
      EXC_HARD:  res = PRIO_HARD;
      default:   res = 4'({1'b0, lvl} + PRIO_CFG_BASE);
    endcase
    return res;
  endfunction

  function automatic logic [59:0] one_hot(input logic hit, input logic [5:0] num);
    return hit ? (60'(1) << num) : '0;
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [2:0]  level [NUM_EXC];
  logic [59:0] enable;
  logic [3:0]  eff [NUM_EXC];
  logic [59:0] raw_req;
  logic [59:0] elig;
  logic [59:0] acc_mask;
  logic [59:0] ret_mask;
  logic [59:0] next_pending;
  logic [59:0] next_active;
  logic        best_valid;
  logic [5:0]  best_num;
  logic [3:0]  best_prio;
  logic [3:0]  cur_run;
  logic        next_take_valid;
  logic [31:0] next_take_addr;
  logic [31:0] wr_base;
  logic        base_ok;
  logic        prio_ok;
  logic        tie_viol;

  // R1 processor exceptions in 0-15, peripheral line n lands at bit n+16
  assign raw_req = {req.irq, req.systick, req.pendable_service_request, 1'b0,
                    req.debug_monitor, req.supervisor_call_exception, 4'h0,
                    req.usage_fault, req.bus_fault, req.mem_fault,
                    req.hard_fault, req.nmi, 2'b00} & VALID_MASK;

  // R16 fixed exceptions ignore the enable bits
  assign elig     = pending & (enable | FIXED_MASK);
  assign acc_mask = one_hot(core.accept, core.accept_number);
  assign ret_mask = one_hot(core.ret, core.ret_number);

  // R15 R18 a new request wins over the accept clear of the same cycle
  assign next_pending = (pending & ~acc_mask) | raw_req;
  assign next_active  = (active & ~ret_mask) | acc_mask;

  // ****************************************
  // Arbitration
  // ****************************************
  always_comb begin
    for (int i = 0; i < NUM_EXC; i++) begin
      eff[i] = eff_level(6'(i), level[i]);
    end
  end

  // R7 R11 R12 strict compare while scanning upward keeps the lowest number on ties
  always_comb begin
    best_valid = 1'b0;
    best_num   = '0;
    best_prio  = PRIO_IDLE;
    cur_run    = PRIO_IDLE;
    tie_viol   = 1'b0;
    for (int i = 0; i < NUM_EXC; i++) begin
      if (elig[i] && (eff[i] < best_prio)) begin
        best_valid = 1'b1;
        best_num   = 6'(i);
        best_prio  = eff[i];
      end
      if (active[i] && (eff[i] < cur_run)) begin
        cur_run = eff[i];
      end
    end
    for (int i = 0; i < NUM_EXC; i++) begin
      if (elig[i] && (6'(i) < best_num) && (eff[i] <= best_prio)) begin
        tie_viol = 1'b1;
      end
    end
  end

  // R13 R14 preempt only on a strictly smaller level; hold off while an accept lands
  assign next_take_valid = best_valid && (best_prio < cur_run) && !core.accept;
  // R1 R2 entry address is base plus four bytes per vector; entry zero is the stack value
  assign next_take_addr  = table_base + 32'({26'h0, best_num}) * ENTRY_BYTES;

  // ****************************************
  // Table base and priority configuration
  // ****************************************
  // Low bits are dropped so a misaligned write cannot skew entries
  assign wr_base = base_wr.vector_table_base_offset & TABLE_ALIGN;
  // R5 unprivileged or out-of-range writes are ignored
  assign base_ok = base_wr.valid && base_wr.privileged &&
                   (wr_base >= TABLE_LO) && (wr_base <= TABLE_HI);
  // R8 writes to fixed exceptions or to missing vectors are ignored
  assign prio_ok = prio_wr.valid && prio_wr.privileged &&
                   (prio_wr.number < 6'(NUM_EXC)) && !FIXED_MASK[prio_wr.number] &&
                   VALID_MASK[prio_wr.number];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      // R4 table returns to zero whatever was relocated before
      table_base <= TABLE_RESET;
    end else if (base_ok) begin
      table_base <= wr_base;
    end
  end

  // R9 R10 three-bit levels reset to zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < NUM_EXC; i++) begin
        level[i] <= LEVEL_RESET;
      end
      enable <= {60{ENABLE_RESET}};
    end else if (prio_ok) begin
      level[prio_wr.number]  <= prio_wr.level;
      enable[prio_wr.number] <= prio_wr.enable;
    end
  end

  // ****************************************
  // Pending, active and take outputs
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pending <= '0;
      active  <= '0;
    end else begin
      pending <= next_pending;
      active  <= next_active;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      take_valid  <= 1'b0;
      take_number <= '0;
      take_addr   <= TABLE_RESET;
      take_prio   <= PRIO_IDLE;
      run_prio    <= PRIO_IDLE;
    end else begin
      take_valid  <= next_take_valid;
      take_number <= best_num;
      take_addr   <= next_take_addr;
      take_prio   <= best_prio;
      run_prio    <= cur_run;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_vector_addr_calc: assert property ( // R1
    @(posedge clk_sys) disable iff (rst)
    take_valid |-> take_addr == $past(table_base) + 32'({26'h0, take_number}) * ENTRY_BYTES)
    else $error("Vector address does not match base plus four per vector");

  a_base_after_reset: assert property ( // R4
    @(posedge clk_sys) rst |=> table_base == TABLE_RESET)
    else $error("Table base not zero after reset");

  a_base_in_range: assert property ( // R5
    @(posedge clk_sys) disable iff (rst)
    (table_base == TABLE_RESET) ||
    ((table_base >= TABLE_LO) && (table_base <= TABLE_HI) && (table_base[7:0] == 8'h00)))
    else $error("Table base outside the allowed window");

  a_base_priv_only: assert property ( // R5
    @(posedge clk_sys) disable iff (rst)
    (base_wr.valid && !base_wr.privileged) |=> $stable(table_base))
    else $error("Unprivileged write moved the table base");

  a_take_strict: assert property ( // R13
    @(posedge clk_sys) disable iff (rst)
    take_valid |-> (take_prio < run_prio) && (take_prio <= PRIO_CFG_MAX))
    else $error("Take offered without strictly higher priority");

  a_tie_lowest: assert property ( // R12
    @(posedge clk_sys) disable iff (rst)
    best_valid |-> !tie_viol)
    else $error("Tie not resolved to lowest exception number");

  a_pend_kept: assert property ( // R15
    @(posedge clk_sys) disable iff (rst)
    1'b1 |=> ((($past(pending) & ~$past(acc_mask)) & ~pending) == '0))
    else $error("Pending flag lost without an accept");

  a_accept_clears: assert property ( // R18
    @(posedge clk_sys) disable iff (rst)
    (core.accept && !raw_req[core.accept_number])
    |=> !pending[$past(core.accept_number)] && active[$past(core.accept_number)])
    else $error("Accept did not move the exception from pending to active");

  a_nmi_first: assert property ( // R16
    @(posedge clk_sys) disable iff (rst)
    (pending[EXC_NMI] && (cur_run > PRIO_NMI) && !core.accept)
    |=> take_valid && (take_number == EXC_NMI))
    else $error("Pending NMI not offered first");

  a_hard_above_cfg: assert property ( // R17
    @(posedge clk_sys) disable iff (rst)
    (pending[EXC_HARD] && !pending[EXC_NMI] && (cur_run > PRIO_HARD) && !core.accept)
    |=> take_valid && (take_number == EXC_HARD) && (take_prio == PRIO_HARD))
    else $error("Pending hard fault not offered ahead of configurable ones");

endmodule

// >>> logic/epvu_pkg.sv
// Shared constants and carrier types for the exception priority and vector unit
package epvu_pkg;

  // ****************************************
  // Exception numbering and table layout
  // ****************************************
  localparam int          NUM_EXC       = 60;
  localparam int          NUM_IRQ       = 44;
  localparam logic [5:0]  EXC_RESET     = 6'h01;
  localparam logic [5:0]  EXC_NMI       = 6'h02;
  localparam logic [5:0]  EXC_HARD      = 6'h03;
  localparam logic [5:0]  IRQ_VEC_BASE  = 6'h10;
  localparam logic [31:0] ENTRY_BYTES   = 32'h0000_0004;
  localparam logic [31:0] TABLE_RESET   = 32'h0000_0000;
  localparam logic [31:0] TABLE_LO      = 32'h0000_0100;
  localparam logic [31:0] TABLE_HI      = 32'h3FFF_FF00;
  localparam logic [31:0] TABLE_ALIGN   = 32'hFFFF_FF00;
  // Implemented vectors: reserved slots and reserved peripheral lines never pend
  localparam logic [59:0] VALID_MASK    = 60'h0C18_F7FF_DDFF_D87C;
  // Reset, NMI and hard fault carry fixed levels
  localparam logic [59:0] FIXED_MASK    = 60'h0000_0000_0000_000E;

  // ****************************************
  // Priority levels, biased by three so they stay unsigned
  // ****************************************
  localparam logic [3:0]  PRIO_RESET    = 4'h0;
  localparam logic [3:0]  PRIO_NMI      = 4'h1;
  localparam logic [3:0]  PRIO_HARD     = 4'h2;
  localparam logic [3:0]  PRIO_CFG_BASE = 4'h3;
  localparam logic [3:0]  PRIO_CFG_MAX  = 4'hA;
  localparam logic [3:0]  PRIO_IDLE     = 4'hF;
  localparam logic [2:0]  LEVEL_RESET   = 3'h0;
  localparam logic        ENABLE_RESET  = 1'b1;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic [43:0] irq;
    logic        systick;
    logic        pendable_service_request;
    logic        debug_monitor;
    logic        supervisor_call_exception;
    logic        usage_fault;
    logic        bus_fault;
    logic        mem_fault;
    logic        hard_fault;
    logic        nmi;
  } epvu_req_type;

  typedef struct packed {
    logic       valid;
    logic       privileged;
    logic [5:0] number;
    logic [2:0] level;
    logic       enable;
  } epvu_prio_wr_type;

  typedef struct packed {
    logic        valid;
    logic        privileged;
    logic [31:0] vector_table_base_offset;
  } epvu_base_wr_type;

  typedef struct packed {
    logic       accept;
    logic [5:0] accept_number;
    logic       ret;
    logic [5:0] ret_number;
  } epvu_core_type;

endpackage

// >>> test/epvu_core_model.sv
// Behavioural processor core that accepts offered exceptions and returns from them
`timescale 1ns/100ps
module epvu_core_model
  import epvu_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       take_valid,
  input  wire logic [5:0] take_number,
  input  wire logic       acc_en,
  input  wire logic       ret_go,
  output epvu_core_type   core
);
  logic [5:0] stack_q[$];

  initial core = '0;

  // ****************************************
  // Accept and return pulses
  // ****************************************
  // Numbers swing away from their last value while the pulse is low,
  // so a design that samples them outside the pulse sees garbage
  always @(negedge clk_sys) begin
    core.accept        <= 1'b0;
    core.ret           <= 1'b0;
    core.accept_number <= ~core.accept_number;
    core.ret_number    <= ~core.ret_number;
    if (rst) begin
      stack_q.delete();
    end else if (acc_en && take_valid && !core.accept) begin
      core.accept        <= 1'b1;
      core.accept_number <= take_number;
      stack_q.push_back(take_number);
    end else if (ret_go && stack_q.size() > 0) begin
      core.ret        <= 1'b1;
      core.ret_number <= stack_q.pop_back();
    end
  end
endmodule

// >>> test/tb_top.sv
// Self-checking bench for the exception priority and vector unit
`timescale 1ns/100ps
module tb_top;
  import epvu_pkg::*;
  logic             clk_sys = 1'b0;
  logic             rst = 1'b1;
  epvu_req_type     req = '0;
  epvu_prio_wr_type prio_wr = '0;
  epvu_base_wr_type base_wr = '0;
  epvu_core_type    core;
  logic             acc_en = 1'b0;
  logic             ret_go = 1'b0;
  logic             take_valid;
  logic [5:0]       take_number;
  logic [31:0]      take_addr;
  logic [3:0]       take_prio;
  logic [3:0]       run_prio;
  logic [59:0]      pending;
  logic [59:0]      active;
  logic [31:0]      table_base;
  int               fails = 0;
  int               cmp_count = 0;
  epvu_req_type     r;

  always #20 clk_sys = ~clk_sys;

  epvu_unit dut (.clk_sys(clk_sys), .rst(rst), .req(req), .prio_wr(prio_wr),
    .base_wr(base_wr), .core(core), .take_valid(take_valid), .take_number(take_number),
    .take_addr(take_addr), .take_prio(take_prio), .run_prio(run_prio),
    .pending(pending), .active(active), .table_base(table_base));
  epvu_core_model core_model (.clk_sys(clk_sys), .rst(rst), .take_valid(take_valid),
    .take_number(take_number), .acc_en(acc_en), .ret_go(ret_go), .core(core));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask

  task automatic close_out();
    if (fails == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(negedge clk_sys);
    rst = 1'b1;
    acc_en <= 1'b0;
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
  endtask

  task automatic wprio(input logic [5:0] num, input logic [2:0] lvl, input logic priv,
                       input logic en = 1'b1);
    @(negedge clk_sys);
    prio_wr = '{1'b1, priv, num, lvl, en};
    @(negedge clk_sys);
    prio_wr = '0;
  endtask

  task automatic wbase(input logic [31:0] a, input logic priv);
    @(negedge clk_sys);
    base_wr = '{1'b1, priv, a};
    @(negedge clk_sys);
    base_wr = '0;
  endtask

  // handler words carry bit 0 set
  function automatic logic [31:0] handler_of(input logic [5:0] vec);
    return 32'h0000_1000 | {24'h00_0000, vec, 2'b01};
  endfunction

  // Ends at the falling edge where a take raised by the request is visible
  task automatic fire(input epvu_req_type q);
    @(negedge clk_sys);
    req = q;
    @(negedge clk_sys);
    req = '0;
    @(negedge clk_sys);
  endtask

  // Handshake signals to the model move by non-blocking assignment to avoid a race
  task automatic ret_one();
    ret_go <= 1'b1;
    @(negedge clk_sys);
    ret_go <= 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic s_vector();
    int irqs[4] = '{0, 8, 31, 43};
    acc_en <= 1'b1;
    foreach (irqs[i]) begin
      r = '0;
      r.irq[irqs[i]] = 1'b1;
      fire(r);
      chk("take_number", 64'(irqs[i] + 16), take_number);
      chk("take_addr", 64'(4 * (irqs[i] + 16)), take_addr);
      chk("handler", 64'(handler_of(6'(irqs[i] + 16))), 64'(handler_of(take_addr[7:2])));
      @(negedge clk_sys);
      chk("pending", 64'h0, pending);
      chk("active", 64'h1 << (irqs[i] + 16), active);
      ret_one();
      chk("run_prio", 64'hF, run_prio);
    end
    r = '0;
    r.irq[9] = 1'b1;
    fire(r);
    chk("reserved", 64'h0, pending);
  endtask

  task automatic s_base();
    wbase(32'h0000_0200, 1'b0);
    chk("table_base", 64'h0, table_base);
    wbase(32'h0000_0200, 1'b1);
    chk("table_base", 64'h0000_0200, table_base);
    wbase(32'h4000_0000, 1'b1);
    chk("table_base", 64'h0000_0200, table_base);
    wbase(32'h0000_0000, 1'b1);
    chk("table_base", 64'h0000_0200, table_base);
    wbase(32'h3FFF_FF00, 1'b1);
    r = '0;
    r.irq[1] = 1'b1;
    fire(r);
    chk("take_addr", 64'h3FFF_FF44, take_addr);
    do_reset();
    chk("table_base", 64'h0, table_base);
  endtask

  task automatic s_prio();
    do_reset();
    wprio(6'h10, 3'h5, 1'b1);
    wprio(6'h11, 3'h2, 1'b1);
    r = '0;
    r.irq[0] = 1'b1;
    r.irq[1] = 1'b1;
    fire(r);
    chk("take_number", 64'h11, take_number);
    chk("take_prio", 64'h5, take_prio);
    do_reset();
    r = '0;
    r.irq[3] = 1'b1;
    r.irq[2] = 1'b1;
    fire(r);
    chk("take_number", 64'h12, take_number);
    chk("take_prio", 64'h3, take_prio);
    do_reset();
    wprio(6'h03, 3'h7, 1'b1);
    r = '0;
    r.hard_fault = 1'b1;
    r.irq[0] = 1'b1;
    fire(r);
    chk("take_number", 64'h3, take_number);
    chk("take_prio", 64'h2, take_prio);
    r = '0;
    r.nmi = 1'b1;
    fire(r);
    chk("take_number", 64'h2, take_number);
    chk("take_prio", 64'h1, take_prio);
  endtask

  task automatic s_system();
    do_reset();
    r = '0;
    r.mem_fault = 1'b1;
    r.bus_fault = 1'b1;
    r.usage_fault = 1'b1;
    r.supervisor_call_exception = 1'b1;
    r.debug_monitor = 1'b1;
    r.pendable_service_request = 1'b1;
    r.systick = 1'b1;
    fire(r);
    chk("pending", 64'h0000_0000_0000_D870, pending);
    chk("take_number", 64'h4, take_number);
    // Masking the winner hands the take to the next source
    wprio(6'h04, 3'h0, 1'b1, 1'b0);
    @(negedge clk_sys);
    chk("take_number", 64'h5, take_number);
    chk("pending", 64'h0000_0000_0000_D870, pending);
    // An unprivileged mask write must leave the source enabled
    wprio(6'h05, 3'h0, 1'b0, 1'b0);
    @(negedge clk_sys);
    chk("take_valid", 64'h1, take_valid);
    chk("take_number", 64'h5, take_number);
  endtask

  task automatic s_preempt();
    do_reset();
    wprio(6'h10, 3'h3, 1'b1);
    wprio(6'h11, 3'h3, 1'b1);
    wprio(6'h12, 3'h2, 1'b1);
    acc_en <= 1'b1;
    r = '0;
    r.irq[1] = 1'b1;
    fire(r);
    chk("take_number", 64'h11, take_number);
    repeat (2) @(negedge clk_sys);
    chk("run_prio", 64'h6, run_prio);
    r = '0;
    r.irq[0] = 1'b1;
    fire(r);
    chk("take_valid", 64'h0, take_valid);
    chk("pending", 64'h1 << 16, pending);
    r = '0;
    r.irq[2] = 1'b1;
    fire(r);
    chk("take_valid", 64'h1, take_valid);
    chk("take_number", 64'h12, take_number);
    @(negedge clk_sys);
    chk("active", 64'h3 << 17, active);
    chk("pending", 64'h1 << 16, pending);
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    do_reset();
    chk("table_base", 64'h0, table_base);
    chk("run_prio", 64'hF, run_prio);
    s_vector();
    s_base();
    s_prio();
    s_system();
    s_preempt();
    close_out();
  end

  // The scenarios take about 125 cycles; this leaves ample slack
  initial begin
    repeat (5000) @(posedge clk_sys);
    fails++;
    close_out();
  end
endmodule
